// [design/cbc_regs.svh]
// Purpose: register offsets, field positions, reset values and timing
// Assumes: 16-bit registers, 100 MHz system clock
// Notes: included by the balance control core only
`ifndef CBC_REGS_SVH
`define CBC_REGS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define CBC_OFS_EXP_BASE 8'h40
`define CBC_OFS_SW_EN 8'h5A
`define CBC_OFS_CTRL 8'h5B
`define CBC_OFS_EXP_COM 8'h5C
`define CBC_OFS_UV_THR 8'h5D
`define CBC_OFS_TIMER 8'h5E
`define CBC_OFS_UV_STAT 8'h5F
`define CBC_OFS_ALERT 8'h60
`define CBC_OFS_SW_DLY 8'h63
`define CBC_OFS_SCAN 8'h66

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define CBC_SCAN_CONT_BIT 0
`define CBC_SCAN_AUTO_OFF_BIT 12
`define CBC_ALERT_BIT 0
`define CBC_RST_SW_DLY 16'h0000
`define CBC_RST_SCAN 16'h0000
`define CBC_RST_EXP 10'h000
`define CBC_RST_UV_THR 16'h0000

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CBC_CLK_NS 10
`define CBC_SEC_NS 1000000000
`define CBC_SEC_CYC (`CBC_SEC_NS / `CBC_CLK_NS)
`define CBC_DLY_UNIT_NS 48000
`define CBC_DLY_UNIT_CYC (`CBC_DLY_UNIT_NS / `CBC_CLK_NS)
`define CBC_SEC_PER_MIN 6'h3B

`endif

// [design/cbc_pkg.sv]
// Purpose: shared types of the cell balance control block
// Assumes: nothing beyond the register header
// Notes: mode codes follow the enum order, disabled is zero
package cbc_pkg;
    typedef enum logic [2:0] {
        CBC_OFF,
        CBC_MAN_SEC,
        CBC_MAN_MIN,
        CBC_AUTO_SEC,
        CBC_AUTO_MIN
    } cbc_mode_e;

    typedef enum logic [0:0] {
        CBC_CV_IDLE,
        CBC_CV_SETTLE
    } cbc_cv_e;

    // register request from the serial link decoder
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } cbc_req_s;

    // balance control register layout
    typedef struct packed {
        logic [3:0] duty;
        logic uv_chk;
        logic [2:0] mode;
    } cbc_ctrl_s;
endpackage

// [design/cbc_core.sv]
// Purpose: balance switch control for a 14-cell monitor
// Assumes: register requests arrive decoded from the daisy-chain link
// Notes:
`timescale 1ns/1ps
`include "cbc_regs.svh"

module cbc_core #(
    parameter int NCELL = 14,
    parameter int SEC_CYC = `CBC_SEC_CYC,
    parameter int UNIT_CYC = `CBC_DLY_UNIT_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire cbc_pkg::cbc_req_s reg_req,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic conv_req,
    input wire logic meas_valid,
    input wire logic [3:0] meas_idx,
    input wire logic [15:0] meas_data,
    output logic [NCELL-1:0] balance_switch_on,
    output logic conv_start,
    output logic interface_fault_alert
);
    import cbc_pkg::*;

    localparam int SW = $clog2(SEC_CYC + 1);
    localparam int UW = $clog2(UNIT_CYC + 1);

    // ------------------------------------------------------------------
    // mode decoding
    // ------------------------------------------------------------------
    function automatic logic is_auto(input logic [2:0] m);
        is_auto = (m == CBC_AUTO_SEC) || (m == CBC_AUTO_MIN);
    endfunction

    function automatic logic is_man(input logic [2:0] m);
        is_man = (m == CBC_MAN_SEC) || (m == CBC_MAN_MIN);
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [15:0] dly_q, dly_d, scan_q, scan_d, uvthr_q, uvthr_d;
    logic [NCELL-1:0] en_q, en_d, uvf_q, uvf_d, sw_q, sw_d, want;
    cbc_ctrl_s ctrl_q, ctrl_d, nctrl;
    logic [9:0] expc_q, expc_d, timer_q, timer_d;
    logic [9:0] exp_q [NCELL];
    logic [9:0] exp_d [NCELL];
    logic [5:0] min_q, min_d;
    logic [SW-1:0] sec_q, sec_d;
    logic [UW-1:0] unit_q, unit_d;
    logic [4:0] duty_q, duty_d;
    logic [8:0] dcnt_q, dcnt_d;
    logic alert_q, alert_d, open_q, open_d, conv_q, conv_d;
    logic [15:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    cbc_cv_e cv_q, cv_d;
    logic sec_tick, unit_tick, tunit, expired, set_alert, clr_alert;
    logic auto_m, man_m, off_m;
    logic [7:0] cidx;

    assign auto_m = is_auto(ctrl_q.mode);
    assign man_m = is_man(ctrl_q.mode);
    assign off_m = ctrl_q.mode == CBC_OFF;
    assign sec_tick = sec_q == SW'(SEC_CYC - 1);
    assign unit_tick = unit_q == UW'(UNIT_CYC - 1);
    assign expired = timer_q >= expc_q;
    assign cidx = reg_req.addr - `CBC_OFS_EXP_BASE;
    assign nctrl = cbc_ctrl_s'(reg_req.wdata[7:0]);

    // ------------------------------------------------------------------
    // per-cell switch decision
    // ------------------------------------------------------------------
    for (genvar i = 0; i < NCELL; i++) begin : g_cell
        always_comb begin
            want[i] = 1'b0;
            if (auto_m) begin
                // adjacent cells sit in opposite phases
                want[i] = en_q[i] && !uvf_q[i] && !expired
                    && (timer_q < exp_q[i])
                    && (duty_q[4] == 1'(i % 2))
                    && (duty_q[3:0] <= ctrl_q.duty);
            end else if (man_m) begin
                want[i] = en_q[i] && !expired && !open_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        dly_d = dly_q;
        scan_d = scan_q;
        uvthr_d = uvthr_q;
        en_d = en_q;
        ctrl_d = ctrl_q;
        expc_d = expc_q;
        exp_d = exp_q;
        timer_d = timer_q;
        min_d = min_q;
        uvf_d = uvf_q;
        set_alert = 1'b0;
        clr_alert = 1'b0;
        cv_d = cv_q;
        dcnt_d = dcnt_q;
        open_d = open_q;
        conv_d = 1'b0;
        rvalid_d = reg_req.rd;
        rdata_d = rdata_q;
        sec_d = sec_tick ? '0 : sec_q + 1'b1;
        unit_d = unit_tick ? '0 : unit_q + 1'b1;
        duty_d = unit_tick ? duty_q + 5'h01 : duty_q;
        // minute modes count whole minutes of seconds
        if (ctrl_q.mode == CBC_MAN_MIN || ctrl_q.mode == CBC_AUTO_MIN) begin
            tunit = sec_tick && (min_q == `CBC_SEC_PER_MIN);
            if (sec_tick) begin
                min_d = (min_q == `CBC_SEC_PER_MIN) ? 6'h00 : min_q + 6'h01;
            end
        end else begin
            tunit = sec_tick;
        end
        // count stops at the programmed expiry
        // manual count needs a closed switch
        if (!off_m && tunit && !expired && (auto_m || (man_m && |sw_q))) begin
            timer_d = timer_q + 10'h001;
        end
        if (auto_m && ctrl_q.uv_chk && meas_valid
                && meas_idx < 4'(NCELL) && meas_data < uvthr_q) begin
            uvf_d[meas_idx] = 1'b1;
        end
        // register writes
        if (reg_req.wr) begin
            case (reg_req.addr)
                `CBC_OFS_SW_DLY: dly_d = reg_req.wdata;
                `CBC_OFS_SCAN: scan_d = reg_req.wdata;
                `CBC_OFS_SW_EN: begin
                    if (auto_m) begin
                        set_alert = 1'b1;
                    end else begin
                        en_d = reg_req.wdata[NCELL-1:0];
                    end
                end
                `CBC_OFS_CTRL: begin
                    // duty or check change refused in auto
                    // leaving auto may rewrite the fields freely
                    if (auto_m && is_auto(nctrl.mode)
                            && (nctrl.duty != ctrl_q.duty
                            || nctrl.uv_chk != ctrl_q.uv_chk)) begin
                        set_alert = 1'b1;
                    end else begin
                        ctrl_d.duty = nctrl.duty;
                        ctrl_d.uv_chk = nctrl.uv_chk;
                    end
                    if (is_auto(nctrl.mode)
                            && scan_q[`CBC_SCAN_CONT_BIT]) begin
                        set_alert = 1'b1;
                    end else if (nctrl.mode > CBC_AUTO_MIN) begin
                        set_alert = 1'b1;
                    end else if (nctrl.mode != ctrl_q.mode) begin
                        ctrl_d.mode = nctrl.mode;
                        timer_d = 10'h000;
                        min_d = 6'h00;
                        uvf_d = '0;
                    end
                end
                `CBC_OFS_EXP_COM: begin
                    // expiry locked while a mode runs
                    if (!off_m) begin
                        set_alert = 1'b1;
                    end else begin
                        expc_d = reg_req.wdata[9:0];
                    end
                end
                `CBC_OFS_UV_THR: begin
                    if (!off_m) begin
                        set_alert = 1'b1;
                    end else begin
                        uvthr_d = reg_req.wdata;
                    end
                end
                `CBC_OFS_ALERT: clr_alert = reg_req.wdata[`CBC_ALERT_BIT];
                default: begin
                    if (cidx < 8'(NCELL)) begin
                        if (!off_m) begin
                            set_alert = 1'b1;
                        end else begin
                            exp_d[cidx[3:0]] = reg_req.wdata[9:0];
                        end
                    end
                end
            endcase
        end
        // a new fault wins over a clear in the same cycle
        alert_d = (alert_q && !clr_alert) || set_alert;
        // register reads
        if (reg_req.rd) begin
            case (reg_req.addr)
                `CBC_OFS_SW_DLY: rdata_d = dly_q;
                `CBC_OFS_SCAN: rdata_d = scan_q;
                `CBC_OFS_SW_EN: rdata_d = 16'(en_q);
                `CBC_OFS_CTRL: rdata_d = 16'(ctrl_q);
                `CBC_OFS_EXP_COM: rdata_d = 16'(expc_q);
                `CBC_OFS_UV_THR: rdata_d = uvthr_q;
                `CBC_OFS_TIMER: rdata_d = {5'h00, expired, timer_q};
                `CBC_OFS_UV_STAT: rdata_d = 16'(uvf_q);
                `CBC_OFS_ALERT: rdata_d = 16'(alert_q);
                default: begin
                    rdata_d = 16'h0000;
                    if (cidx < 8'(NCELL)) begin
                        rdata_d = 16'(exp_q[cidx[3:0]]);
                    end
                end
            endcase
        end
        // conversion sequencing
        case (cv_q)
            CBC_CV_IDLE: begin
                // switch-off on convert only in manual
                if (conv_req && man_m
                        && scan_q[`CBC_SCAN_AUTO_OFF_BIT]) begin
                    open_d = 1'b1;
                    dcnt_d = 9'(dly_q[15:8]) + 9'(dly_q[7:0]);
                    cv_d = CBC_CV_SETTLE;
                end else if (conv_req) begin
                    conv_d = 1'b1;
                end
            end
            CBC_CV_SETTLE: begin
                if (dcnt_q == 9'h000) begin
                    conv_d = 1'b1;
                    open_d = 1'b0;
                    cv_d = CBC_CV_IDLE;
                end else if (unit_tick) begin
                    dcnt_d = dcnt_q - 9'h001;
                end
            end
            default: cv_d = CBC_CV_IDLE;
        endcase
        sw_d = want;
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dly_q <= `CBC_RST_SW_DLY;
            scan_q <= `CBC_RST_SCAN;
            uvthr_q <= `CBC_RST_UV_THR;
            en_q <= '0;
            ctrl_q <= '0;
            expc_q <= `CBC_RST_EXP;
            for (int k = 0; k < NCELL; k++) begin
                exp_q[k] <= `CBC_RST_EXP;
            end
            timer_q <= 10'h000;
            min_q <= 6'h00;
            uvf_q <= '0;
            sec_q <= '0;
            unit_q <= '0;
            duty_q <= 5'h00;
            dcnt_q <= 9'h000;
            alert_q <= 1'b0;
            open_q <= 1'b0;
            conv_q <= 1'b0;
            sw_q <= '0;
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
            cv_q <= CBC_CV_IDLE;
        end else begin
            dly_q <= dly_d;
            scan_q <= scan_d;
            uvthr_q <= uvthr_d;
            en_q <= en_d;
            ctrl_q <= ctrl_d;
            expc_q <= expc_d;
            exp_q <= exp_d;
            timer_q <= timer_d;
            min_q <= min_d;
            uvf_q <= uvf_d;
            sec_q <= sec_d;
            unit_q <= unit_d;
            duty_q <= duty_d;
            dcnt_q <= dcnt_d;
            alert_q <= alert_d;
            open_q <= open_d;
            conv_q <= conv_d;
            sw_q <= sw_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            cv_q <= cv_d;
        end
    end

    assign balance_switch_on = sw_q;
    assign conv_start = conv_q;
    assign interface_fault_alert = alert_q;
    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_open_req;
        cv_q == CBC_CV_IDLE && conv_req && man_m
            && scan_q[`CBC_SCAN_AUTO_OFF_BIT];
    endsequence

    sequence s_switches_open;
        open_q ##1 (sw_q == '0);
    endsequence

    a_auto_no_adjacent: assert property (
        auto_m && $past(auto_m) |-> (sw_q & (sw_q >> 1)) == '0)
        else $error("adjacent switches closed in auto mode");
    a_auto_one_phase: assert property (
        auto_m && $past(auto_m)
            |-> !(|(sw_q & 14'h1555) && |(sw_q & 14'h2AAA)))
        else $error("both switch phases closed together");
    a_off_opens_all: assert property (
        off_m && $past(off_m) |-> sw_q == '0 && $stable(timer_q))
        else $error("switches or timer active while disabled");
    a_expiry_write_alert: assert property (
        reg_req.wr && reg_req.addr == `CBC_OFS_EXP_COM && !off_m
            |=> alert_q && $stable(expc_q))
        else $error("expiry write in active mode not flagged");
    a_auto_enable_alert: assert property (
        reg_req.wr && reg_req.addr == `CBC_OFS_SW_EN && auto_m
            |=> alert_q && $stable(en_q))
        else $error("enable change in auto mode not flagged");
    a_convert_opens: assert property (
        s_open_req |=> s_switches_open)
        else $error("switches not opened for conversion");
    a_auto_convert_direct: assert property (
        cv_q == CBC_CV_IDLE && conv_req && auto_m |=> conv_q && !open_q)
        else $error("auto mode conversion delayed");
    a_settle_zero_delay: assert property (
        (s_open_req and dly_q == 16'h0000) |=> ##1 conv_q)
        else $error("zero delay conversion not started");
    a_uv_open: assert property (
        auto_m && $past(auto_m) && $past(uvf_q) == uvf_q
            |-> (uvf_q & sw_q) == '0)
        else $error("flagged cell switch closed");
    a_timer_bound: assert property (
        !off_m && expired |=> timer_q <= $past(timer_q) || !$stable(ctrl_q))
        else $error("timer ran past expiry");
    a_manual_enable_take: assert property (
        reg_req.wr && reg_req.addr == `CBC_OFS_SW_EN && man_m
            |=> en_q == $past(reg_req.wdata[NCELL-1:0]))
        else $error("manual enable write not taken");
endmodule

// [testbench/cbc_host_model.sv]
// Purpose: host side of the register link, drives decoded requests
// Assumes: requests change on the falling edge, one per transfer
// Notes: released address and data show the inverse of the last value
`timescale 1ns/1ps
module cbc_host_model (
    input wire logic clk_sys,
    output cbc_pkg::cbc_req_s reg_req,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid
);
    import cbc_pkg::*;
    initial reg_req = '0;

    // one write, strobe held across a single rising edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        reg_req = '{1'b1, 1'b0, a, d};
        @(negedge clk_sys);
        reg_req = '{1'b0, 1'b0, ~a, ~d};
    endtask

    // one read, data taken while the answer pulse is high
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        int n;
        @(negedge clk_sys);
        reg_req = '{1'b0, 1'b1, a, 16'h0000};
        @(negedge clk_sys);
        reg_req = '{1'b0, 1'b0, ~a, 16'hFFFF};
        for (n = 0; n < 3 && reg_rvalid !== 1'b1; n++) @(negedge clk_sys);
        d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hxxxx;
    endtask

    task automatic set_param(input logic [7:0] a, input logic [15:0] d);
        wr(8'h5B, 16'h0000);
        wr(a, d);
    endtask

    task automatic go_auto(input logic [15:0] ctrl);
        wr(8'h66, 16'h1000);
        wr(8'h5B, ctrl);
    endtask
endmodule

// [testbench/cell_balance_control_tb.sv]
// Purpose: self-checking bench of the balance switch control core
// Assumes: shortened second and delay unit counts
// Notes: inputs change on the falling edge only
`timescale 1ns/1ps
module cell_balance_control_tb;
    import cbc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    cbc_req_s reg_req;
    logic [15:0] reg_rdata, rdat, meas_data;
    logic reg_rvalid, conv_req, meas_valid, conv_start, alert;
    logic [3:0] meas_idx;
    logic [13:0] sw, s;
    int mismatches = 0;
    int n_compared = 0;
    int cyc = 0;
    int n, adj, on0, on1, b2, t0;

    cbc_core #(.NCELL(14), .SEC_CYC(20), .UNIT_CYC(4)) i_cbc_core (
        .clk_sys(clk_sys), .rst(rst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .conv_req(conv_req), .meas_valid(meas_valid),
        .meas_idx(meas_idx), .meas_data(meas_data),
        .balance_switch_on(sw), .conv_start(conv_start),
        .interface_fault_alert(alert)
    );
    cbc_host_model i_cbc_host_model (
        .clk_sys(clk_sys), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
    );

    // ------------------------------------------------------------------
    // clock, hang guard and helpers
    // ------------------------------------------------------------------
    initial forever #5 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic cmp16(input logic [15:0] g, e, input string m);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: %s %h/%h", $time, m, g, e);
        end
    endtask

    task automatic cmp1(input logic g, input string m);
        n_compared++;
        if (g !== 1'b1) begin
            mismatches++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
        i_cbc_host_model.rd(a, rdat);
        cmp16(rdat, e, "read");
    endtask

    // conversion request, cycles until start and switches seen then
    task automatic conv(output int k, output logic [13:0] q);
        conv_req = 1'b1;
        @(negedge clk_sys);
        conv_req = 1'b0;
        for (k = 1; k < 200 && conv_start !== 1'b1; k++) @(negedge clk_sys);
        q = sw;
    endtask

    // switch activity over k cycles
    task automatic watch(input int k);
        adj = 0;
        on0 = 0;
        on1 = 0;
        b2 = 0;
        repeat (k) begin
            @(negedge clk_sys);
            if ((sw & (sw >> 1)) !== 14'h0) adj++;
            if (sw[0] === 1'b1) on0++;
            if (sw[1] === 1'b1) on1++;
            if (sw[2] !== 1'b0) b2++;
        end
    endtask

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        conv_req = 1'b0;
        meas_valid = 1'b0;
        meas_idx = 4'h0;
        meas_data = 16'h0000;
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        chk_rd(8'h63, 16'h0000);
        chk_rd(8'h66, 16'h0000);
        chk_rd(8'h70, 16'h0000);
        cmp1(alert === 1'b0, "alert idle");
        $display("test reset done");

        i_cbc_host_model.set_param(8'h5C, 16'h0003);
        i_cbc_host_model.wr(8'h5A, 16'h0155);
        i_cbc_host_model.wr(8'h5B, 16'h0001);
        watch(30);
        cmp16(sw, 16'h0155, "manual on");
        cmp16(on0[15:0], 16'h001E, "duty ignored");
        i_cbc_host_model.wr(8'h5A, 16'h0AAA);
        watch(2);
        cmp16(sw, 16'h0AAA, "live enable");
        i_cbc_host_model.wr(8'h5C, 16'h0010);
        watch(2);
        cmp1(alert, "expiry write alert");
        chk_rd(8'h5C, 16'h0003);
        i_cbc_host_model.wr(8'h60, 16'h0001);
        watch(2);
        cmp1(alert === 1'b0, "alert clear");
        for (n = 0; n < 200 && sw !== 14'h0; n++) @(negedge clk_sys);
        cmp16(sw, 16'h0000, "expired open");
        i_cbc_host_model.rd(8'h5E, rdat);
        cmp1(rdat[10], "expired flag");
        i_cbc_host_model.wr(8'h5B, 16'h0000);
        watch(2);
        cmp16(sw, 16'h0000, "disabled open");
        chk_rd(8'h5E, 16'h0000);
        chk_rd(8'h5C, 16'h0003);
        $display("test manual done");

        i_cbc_host_model.set_param(8'h5C, 16'h03FF);
        i_cbc_host_model.wr(8'h5A, 16'h0155);
        i_cbc_host_model.wr(8'h63, 16'h0102);
        i_cbc_host_model.wr(8'h66, 16'h1000);
        i_cbc_host_model.wr(8'h5B, 16'h0001);
        watch(2);
        conv(n, s);
        cmp1(n >= 9 && n <= 16, "settle length");
        cmp16(s, 16'h0000, "open for conversion");
        watch(2);
        cmp16(sw, 16'h0155, "reclosed");
        i_cbc_host_model.wr(8'h63, 16'h0000);
        conv(n, s);
        cmp16(n[15:0], 16'h0002, "zero delay");
        i_cbc_host_model.wr(8'h66, 16'h0000);
        conv(n, s);
        cmp16(n[15:0], 16'h0001, "no switch off");
        cmp16(s, 16'h0155, "stay closed");
        $display("test conversion done");

        i_cbc_host_model.wr(8'h66, 16'h0001);
        i_cbc_host_model.wr(8'h5B, 16'h00FB);
        watch(2);
        cmp1(alert, "scan running alert");
        i_cbc_host_model.rd(8'h5B, rdat);
        cmp16(rdat[2:0], 16'h0001, "mode kept");
        i_cbc_host_model.wr(8'h60, 16'h0001);
        $display("test scan refusal done");

        i_cbc_host_model.set_param(8'h5D, 16'h8000);
        for (t0 = 0; t0 < 14; t0++) begin
            i_cbc_host_model.wr(8'h40 + t0[7:0], 16'h03FF);
        end
        i_cbc_host_model.wr(8'h5A, 16'h3FFF);
        i_cbc_host_model.go_auto(16'h00FB);
        meas_valid = 1'b1;
        meas_idx = 4'h2;
        meas_data = 16'h1000;
        @(negedge clk_sys);
        meas_valid = 1'b0;
        watch(3);
        watch(200);
        cmp16(adj[15:0], 16'h0000, "adjacent closed");
        cmp1(on0 > 0 && on1 > 0 && on0 < 200, "interleave");
        cmp16(b2[15:0], 16'h0000, "uv cell open");
        chk_rd(8'h5F, 16'h0004);
        conv(n, s);
        cmp16(n[15:0], 16'h0001, "auto ignores off");
        i_cbc_host_model.rd(8'h5E, rdat);
        t0 = rdat[9:0];
        watch(60);
        i_cbc_host_model.rd(8'h5E, rdat);
        cmp1(rdat[9:0] > t0, "auto counting");
        i_cbc_host_model.wr(8'h5A, 16'h0001);
        watch(2);
        cmp1(alert, "auto param alert");
        chk_rd(8'h5A, 16'h3FFF);
        i_cbc_host_model.wr(8'h60, 16'h0001);
        i_cbc_host_model.wr(8'h5B, 16'h0000);
        watch(2);
        cmp1(alert === 1'b0, "leaving auto clean");
        $display("test auto done");

        // minute mode counts whole minutes only
        i_cbc_host_model.wr(8'h5A, 16'h0001);
        i_cbc_host_model.wr(8'h5B, 16'h0002);
        watch(100);
        chk_rd(8'h5E, 16'h0000);
        watch(1200);
        chk_rd(8'h5E, 16'h0001);
        $display("test minute done");
        print_verdict();
    end
endmodule
